// File: rtl/alhr_consts.vh
`ifndef ALHR_CONSTS_VH
`define ALHR_CONSTS_VH
// Own register map, byte offsets on the APB slave.
`define ALHR_OFS_CMD        8'h00
`define ALHR_OFS_ADDR_LO    8'h04
`define ALHR_OFS_ADDR_HI    8'h08
`define ALHR_OFS_TAG        8'h0C
`define ALHR_OFS_BYTES      8'h10
`define ALHR_OFS_WDATA      8'h14
`define ALHR_OFS_STATUS     8'h18
`define ALHR_OFS_RD_CNT     8'h1C
`define ALHR_OFS_WR_CNT     8'h20
`define ALHR_OFS_MSG_CNT    8'h24
`define ALHR_OFS_LAST_HDR   8'h28
`define ALHR_OFS_LAST_DATA  8'h2C
`define ALHR_OFS_MAILBOX    8'h30
`define ALHR_RESET_WORD     32'h00000000
// Write request header fields.
`define ALHR_WH_BLEN_HI     79
`define ALHR_WH_BLEN_LO     74
`define ALHR_WH_CHSEL_HI    73
`define ALHR_WH_CHSEL_LO    72
`define ALHR_WH_FIRST       71
`define ALHR_WH_MODE        70
`define ALHR_WH_LCNT_HI     69
`define ALHR_WH_LCNT_LO     68
`define ALHR_WH_TYPE_HI     67
`define ALHR_WH_TYPE_LO     64
`define ALHR_WH_BSTART_HI   63
`define ALHR_WH_BSTART_LO   58
`define ALHR_WH_ADDR_HI     57
`define ALHR_WH_ADDR_LO     18
`define ALHR_WH_ALOW_HI     17
`define ALHR_WH_ALOW_LO     16
`define ALHR_WH_TAG_HI      15
`define ALHR_WH_TAG_LO      0
`define ALHR_MODE_FULL      1'b0
`define ALHR_MODE_PARTIAL   1'b1
// Write channel request kinds.
`define ALHR_WRITE_NO_CACHE      4'h0
`define ALHR_WRITE_MODIFIED_HINT 4'h1
`define ALHR_WRITE_PUSH_LLC      4'h2
`define ALHR_WRITE_FENCE_KIND    4'h4
`define ALHR_INTERRUPT_KIND      4'h6
// Receive header fields.
`define ALHR_RH_TYPE_HI     27
`define ALHR_RH_TYPE_LO     24
`define ALHR_RH_FORMAT      23
`define ALHR_RH_CLNUM_HI    21
`define ALHR_RH_CLNUM_LO    20
`define ALHR_RSP_RDLINE     4'h0
`define ALHR_RSP_WRLINE     4'h1
`define ALHR_RSP_MESSAGE    4'h4
// Register request header fields.
`define ALHR_QH_ADDR_HI     27
`define ALHR_QH_ADDR_LO     12
`define ALHR_QH_LEN_HI      11
`define ALHR_QH_LEN_LO      10
`define ALHR_QH_TID_HI      8
`define ALHR_QH_TID_LO      0
`define ALHR_LEN_4B         2'h0
`define ALHR_LEN_8B         2'h1
`define ALHR_LEN_64B        2'h2
`define ALHR_CREDIT_MAX     8'h40
`endif

// File: rtl/alhr_wr_hdr.v
`timescale 1ns/1ps
`default_nettype none
`include "alhr_consts.vh"
module alhr_wr_hdr (
    // Request fields
    input  wire [3:0]  req_type,
    input  wire [1:0]  channel_select,
    input  wire [1:0]  line_count,
    input  wire        partial,
    input  wire [5:0]  byte_start,
    input  wire [5:0]  byte_len,
    input  wire [41:0] line_addr,
    input  wire [15:0] tag,
    input  wire [1:0]  interrupt_vector,
    input  wire [1:0]  beat,
    // Packed header
    output reg  [79:0] hdr
);
    wire       first   = (beat == 2'h0);
    wire [1:0] low_adr = line_addr[1:0] + beat;

    always @* begin
        hdr = 80'h0;
        hdr[`ALHR_WH_TYPE_HI:`ALHR_WH_TYPE_LO] = req_type;
        if (req_type == `ALHR_WRITE_FENCE_KIND) begin
            hdr[`ALHR_WH_CHSEL_HI:`ALHR_WH_CHSEL_LO] = channel_select;
            hdr[`ALHR_WH_TAG_HI:`ALHR_WH_TAG_LO]     = tag;
        end else if (req_type == `ALHR_INTERRUPT_KIND) begin
            hdr[`ALHR_WH_CHSEL_HI:`ALHR_WH_CHSEL_LO] = channel_select;
            hdr[1:0]                                 = interrupt_vector;
        end else if (first) begin
            hdr[`ALHR_WH_FIRST]                        = 1'b1;
            hdr[`ALHR_WH_CHSEL_HI:`ALHR_WH_CHSEL_LO]   = channel_select;
            hdr[`ALHR_WH_LCNT_HI:`ALHR_WH_LCNT_LO]     = line_count;
            hdr[`ALHR_WH_MODE] = partial ? `ALHR_MODE_PARTIAL : `ALHR_MODE_FULL;
            hdr[`ALHR_WH_ADDR_HI:`ALHR_WH_ADDR_LO]     = line_addr[41:2];
            hdr[`ALHR_WH_ALOW_HI:`ALHR_WH_ALOW_LO]     = line_addr[1:0];
            hdr[`ALHR_WH_TAG_HI:`ALHR_WH_TAG_LO]       = tag;
            if (partial) begin
                hdr[`ALHR_WH_BLEN_HI:`ALHR_WH_BLEN_LO]     = byte_len;
                hdr[`ALHR_WH_BSTART_HI:`ALHR_WH_BSTART_LO] = byte_start;
            end
        end else begin
            hdr[`ALHR_WH_MODE]                     = `ALHR_MODE_FULL;
            hdr[`ALHR_WH_ALOW_HI:`ALHR_WH_ALOW_LO] = low_adr;
        end
    end
endmodule // alhr_wr_hdr
`default_nettype wire

// File: rtl/alhr_reg_resp.v
`timescale 1ns/1ps
`default_nettype none
`include "alhr_consts.vh"
module alhr_reg_resp (
    // Clock and reset
    input  wire        pclk,
    input  wire        presetn,
    // Register requests from the interface unit
    input  wire        reg_read_strobe,
    input  wire        reg_write_strobe,
    input  wire [27:0] req_hdr,
    input  wire [63:0] req_data,
    // Read reply, and scratch word 0
    output reg         reply_valid_reg,
    output reg  [8:0]  reply_hdr_reg,
    output reg  [63:0] reply_data_reg,
    output wire [63:0] scratch_word
);
    // Eight 64-bit scratch words; a 64-byte write lands only its low word.
    reg  [63:0] mem [0:7];
    wire [15:0] dw_addr = req_hdr[`ALHR_QH_ADDR_HI:`ALHR_QH_ADDR_LO];
    wire [2:0]  idx     = dw_addr[3:1];
    wire [1:0]  len     = req_hdr[`ALHR_QH_LEN_HI:`ALHR_QH_LEN_LO];
    integer     i;

    assign scratch_word = mem[0];

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reply_valid_reg <= 1'b0;
            reply_hdr_reg   <= 9'h000;
            reply_data_reg  <= 64'h0;
            for (i = 0; i < 8; i = i + 1) begin
                mem[i] <= 64'h0;
            end
        end else begin
            // Every request is taken in its own cycle; there is no way to stall.
            reply_valid_reg <= reg_read_strobe;
            if (reg_read_strobe) begin
                reply_hdr_reg  <= req_hdr[`ALHR_QH_TID_HI:`ALHR_QH_TID_LO];
                reply_data_reg <= (len == `ALHR_LEN_4B) ?
                                  {32'h0, dw_addr[0] ? mem[idx][63:32] : mem[idx][31:0]} :
                                  mem[idx];
            end
            if (reg_write_strobe) begin
                if (len == `ALHR_LEN_4B) begin
                    if (dw_addr[0]) begin
                        mem[idx][63:32] <= req_data[31:0];
                    end else begin
                        mem[idx][31:0] <= req_data[31:0];
                    end
                end else begin
                    mem[idx] <= req_data;
                end
            end
        end
    end
endmodule // alhr_reg_resp
`default_nettype wire

// File: rtl/alhr_top.v
// Our own choices: the APB register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "alhr_consts.vh"
module alhr_top (
    // Clock and reset
    input  wire         pclk,
    input  wire         presetn,
    // APB slave
    input  wire         psel,
    input  wire         penable,
    input  wire         pwrite,
    input  wire [7:0]   paddr,
    input  wire [31:0]  pwdata,
    output reg  [31:0]  prdata_reg,
    output reg          pready_reg,
    output reg          pslverr_reg,
    // Transmit backpressure
    input  wire         read_req_nearly_full,
    input  wire         write_req_nearly_full,
    // Transmit channel 1
    output reg          tx1_valid_reg,
    output reg  [79:0]  tx1_hdr_reg,
    output reg  [511:0] tx1_data_reg,
    // Transmit channel 2, register read replies
    output wire         tx2_valid,
    output wire [8:0]   tx2_hdr,
    output wire [63:0]  tx2_data,
    // Receive channel 0
    input  wire [27:0]  rx0_hdr,
    input  wire [511:0] rx0_data,
    input  wire         rx0_response_strobe,
    input  wire         reg_read_strobe,
    input  wire         reg_write_strobe,
    // Receive channel 1
    input  wire [27:0]  rx1_hdr,
    input  wire         rx1_response_strobe
);
    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_SEND = 2'h1;

    reg  [1:0]  state_reg;
    reg  [1:0]  beat_reg;
    reg  [10:0] cmd_reg;
    reg  [31:0] addr_lo_reg;
    reg  [9:0]  addr_hi_reg;
    reg  [15:0] tag_reg;
    reg  [13:0] bytes_reg;
    reg  [31:0] wdata_reg;
    reg         dropped_reg;
    reg  [7:0]  outstanding_reg;
    reg  [7:0]  outstanding_next;
    reg  [31:0] rd_cnt_reg;
    reg  [31:0] wr_cnt_reg;
    reg  [31:0] msg_cnt_reg;
    reg  [27:0] last_hdr_reg;
    reg  [31:0] last_data_reg;
    reg  [31:0] rd_mux;
    reg         map_hit;
    wire [79:0] hdr_w;
    wire [63:0] scratch_word;

    // Command word fields.
    wire [3:0] c_type   = cmd_reg[3:0];
    wire [1:0] c_chsel  = cmd_reg[5:4];
    wire [1:0] c_lcount = cmd_reg[7:6];
    wire       c_part   = cmd_reg[8];
    wire [1:0] c_vector = cmd_reg[10:9];
    wire       c_write  = (c_type == `ALHR_WRITE_NO_CACHE) ||
                          (c_type == `ALHR_WRITE_MODIFIED_HINT) ||
                          (c_type == `ALHR_WRITE_PUSH_LLC);
    wire [3:0] p_type   = pwdata[3:0];
    wire       p_legal  = (p_type == `ALHR_WRITE_NO_CACHE) ||
                          (p_type == `ALHR_WRITE_MODIFIED_HINT) ||
                          (p_type == `ALHR_WRITE_PUSH_LLC) ||
                          (p_type == `ALHR_WRITE_FENCE_KIND) ||
                          (p_type == `ALHR_INTERRUPT_KIND);

    // Bus handshake: no wait state, pready is registered from the setup phase and the first access cycle completes.
    wire       setup_ph = psel && !penable;
    wire       access   = psel && penable && pready_reg;
    wire       wr_acc   = access && pwrite;
    wire       cmd_wr   = wr_acc && (paddr == `ALHR_OFS_CMD);
    wire       clr_drop = wr_acc && (paddr == `ALHR_OFS_STATUS) && pwdata[1];

    wire [2:0] beats      = {1'b0, c_lcount} + 3'h1;
    wire [7:0] need_lines = {5'h00, beats};
    wire       last_beat  = (beat_reg == c_lcount);
    // Credit is checked only for the first beat; the whole burst is booked then.
    wire       credit_ok  = ({1'b0, outstanding_reg} + {1'b0, need_lines})
                            <= {1'b0, `ALHR_CREDIT_MAX};
    wire       can_issue  = (state_reg == ST_SEND) && !write_req_nearly_full &&
                            (!c_write || beat_reg != 2'h0 || credit_ok);
    wire       book       = can_issue && c_write && (beat_reg == 2'h0);

    // Channel 1 write responses free the space reserved for them.
    wire       rx1_is_wr  = rx1_response_strobe &&
                            (rx1_hdr[`ALHR_RH_TYPE_HI:`ALHR_RH_TYPE_LO] == `ALHR_RSP_WRLINE);
    wire [1:0] rx1_clnum  = rx1_hdr[`ALHR_RH_CLNUM_HI:`ALHR_RH_CLNUM_LO];
    wire [7:0] freed      = rx1_hdr[`ALHR_RH_FORMAT] ?
                            {6'h00, rx1_clnum} + 8'h01 : 8'h01;

    // Channel 0 memory traffic; register strobes go to the responder instead.
    wire       rx0_mem    = rx0_response_strobe && !reg_read_strobe &&
                            !reg_write_strobe;
    wire [3:0] rx0_type   = rx0_hdr[`ALHR_RH_TYPE_HI:`ALHR_RH_TYPE_LO];

    alhr_wr_hdr u_hdr (
        .req_type         (c_type),
        .channel_select   (c_chsel),
        .line_count       (c_lcount),
        .partial          (c_part),
        .byte_start       (bytes_reg[5:0]),
        .byte_len         (bytes_reg[13:8]),
        .line_addr        ({addr_hi_reg, addr_lo_reg}),
        .tag              (tag_reg),
        .interrupt_vector (c_vector),
        .beat             (beat_reg),
        .hdr              (hdr_w)
    );

    alhr_reg_resp u_reg (
        .pclk             (pclk),
        .presetn          (presetn),
        .reg_read_strobe  (reg_read_strobe),
        .reg_write_strobe (reg_write_strobe),
        .req_hdr          (rx0_hdr),
        .req_data         (rx0_data[63:0]),
        .reply_valid_reg  (tx2_valid),
        .reply_hdr_reg    (tx2_hdr),
        .reply_data_reg   (tx2_data),
        .scratch_word     (scratch_word)
    );

    always @* begin
        map_hit = 1'b1;
        case (paddr)
            `ALHR_OFS_CMD:       rd_mux = {21'h000000, cmd_reg};
            `ALHR_OFS_ADDR_LO:   rd_mux = addr_lo_reg;
            `ALHR_OFS_ADDR_HI:   rd_mux = {22'h000000, addr_hi_reg};
            `ALHR_OFS_TAG:       rd_mux = {16'h0000, tag_reg};
            `ALHR_OFS_BYTES:     rd_mux = {18'h00000, bytes_reg};
            `ALHR_OFS_WDATA:     rd_mux = wdata_reg;
            `ALHR_OFS_STATUS:    rd_mux = {16'h0000, outstanding_reg, 4'h0,
                                           write_req_nearly_full, read_req_nearly_full,
                                           dropped_reg, (state_reg != ST_IDLE)};
            `ALHR_OFS_RD_CNT:    rd_mux = rd_cnt_reg;
            `ALHR_OFS_WR_CNT:    rd_mux = wr_cnt_reg;
            `ALHR_OFS_MSG_CNT:   rd_mux = msg_cnt_reg;
            `ALHR_OFS_LAST_HDR:  rd_mux = {4'h0, last_hdr_reg};
            `ALHR_OFS_LAST_DATA: rd_mux = last_data_reg;
            `ALHR_OFS_MAILBOX:   rd_mux = scratch_word[31:0];
            default: begin
                rd_mux  = `ALHR_RESET_WORD;
                map_hit = 1'b0;
            end
        endcase
    end

    always @* begin
        outstanding_next = outstanding_reg;
        if (book) begin
            outstanding_next = outstanding_next + need_lines;
        end
        if (rx1_is_wr) begin
            outstanding_next = (outstanding_next > freed) ?
                               outstanding_next - freed : 8'h00;
        end
    end

    // Bus slave.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg  <= 1'b0;
            prdata_reg  <= `ALHR_RESET_WORD;
            pslverr_reg <= 1'b0;
            addr_lo_reg <= `ALHR_RESET_WORD;
            addr_hi_reg <= 10'h000;
            tag_reg     <= 16'h0000;
            bytes_reg   <= 14'h0000;
            wdata_reg   <= `ALHR_RESET_WORD;
        end else begin
            pready_reg  <= setup_ph;
            pslverr_reg <= setup_ph && !map_hit;
            if (setup_ph) begin
                prdata_reg <= pwrite ? `ALHR_RESET_WORD : rd_mux;
            end
            if (wr_acc) begin
                case (paddr)
                    `ALHR_OFS_ADDR_LO: addr_lo_reg <= pwdata;
                    `ALHR_OFS_ADDR_HI: addr_hi_reg <= pwdata[9:0];
                    `ALHR_OFS_TAG:     tag_reg     <= pwdata[15:0];
                    `ALHR_OFS_BYTES:   bytes_reg   <= {pwdata[13:8], 2'h0, pwdata[5:0]};
                    `ALHR_OFS_WDATA:   wdata_reg   <= pwdata;
                    default: begin
                    end
                endcase
            end
        end
    end

    // Request sequencer for channel 1.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg       <= ST_IDLE;
            beat_reg        <= 2'h0;
            cmd_reg         <= 11'h000;
            dropped_reg     <= 1'b0;
            outstanding_reg <= 8'h00;
            tx1_valid_reg   <= 1'b0;
            tx1_hdr_reg     <= 80'h0;
            tx1_data_reg    <= 512'h0;
        end else begin
            outstanding_reg <= outstanding_next;
            tx1_valid_reg   <= can_issue;
            // A command refused while busy or of unknown kind is flagged, and a
            // new refusal beats a clear arriving in the same cycle.
            if (cmd_wr && (state_reg != ST_IDLE || !p_legal)) begin
                dropped_reg <= 1'b1;
            end else if (clr_drop) begin
                dropped_reg <= 1'b0;
            end
            case (state_reg)
                ST_IDLE: begin
                    if (cmd_wr && p_legal) begin
                        cmd_reg   <= pwdata[10:0];
                        beat_reg  <= 2'h0;
                        state_reg <= ST_SEND;
                    end
                end
                ST_SEND: begin
                    if (can_issue) begin
                        tx1_hdr_reg  <= hdr_w;
                        tx1_data_reg <= {16{wdata_reg}};
                        if (c_write && !last_beat) begin
                            beat_reg <= beat_reg + 2'h1;
                        end else begin
                            state_reg <= ST_IDLE;
                        end
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // Receive bookkeeping; strobes are never pushed back.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_cnt_reg    <= `ALHR_RESET_WORD;
            wr_cnt_reg    <= `ALHR_RESET_WORD;
            msg_cnt_reg   <= `ALHR_RESET_WORD;
            last_hdr_reg  <= 28'h0000000;
            last_data_reg <= `ALHR_RESET_WORD;
        end else begin
            if (rx0_mem) begin
                last_hdr_reg  <= rx0_hdr;
                last_data_reg <= rx0_data[31:0];
                if (rx0_type == `ALHR_RSP_RDLINE) begin
                    rd_cnt_reg <= rd_cnt_reg + 32'h1;
                end else if (rx0_type == `ALHR_RSP_MESSAGE) begin
                    msg_cnt_reg <= msg_cnt_reg + 32'h1;
                end
            end
            if (rx1_response_strobe) begin
                wr_cnt_reg <= wr_cnt_reg + 32'h1;
            end
        end
    end
endmodule // alhr_top
`default_nettype wire

// File: test/alhr_props.sv
`timescale 1ns/1ps
`default_nettype none
module alhr_props (
    // Clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pready_reg,
    input wire logic        pslverr_reg,
    // Transmit
    input wire logic        write_req_nearly_full,
    input wire logic        tx1_valid_reg,
    input wire logic [79:0] tx1_hdr_reg,
    input wire logic        tx2_valid,
    input wire logic [8:0]  tx2_hdr,
    // Receive
    input wire logic [27:0] rx0_hdr,
    input wire logic        reg_read_strobe
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_after_setup: assert property (psel && !penable |=> pready_reg)
        else $error("pready missing after setup");
    a_ready_one_cycle: assert property (pready_reg |=> !pready_reg)
        else $error("pready held too long");
    a_err_with_ready: assert property (pslverr_reg |-> pready_reg)
        else $error("pslverr without pready");
    a_full_blocks_beat: assert property (write_req_nearly_full |=> !tx1_valid_reg)
        else $error("beat issued while nearly full");
    a_later_full_line: assert property (tx1_valid_reg && !tx1_hdr_reg[71] |->
        !tx1_hdr_reg[70] && tx1_hdr_reg[79:74] == 6'h00 && tx1_hdr_reg[63:58] == 6'h00)
        else $error("later beat not full line");
    a_full_no_bytes: assert property (tx1_valid_reg && tx1_hdr_reg[67:64] < 4'h4 &&
        !tx1_hdr_reg[70] |-> tx1_hdr_reg[79:74] == 6'h00 && tx1_hdr_reg[63:58] == 6'h00)
        else $error("byte fields set in full line mode");
    a_next_beat_addr: assert property (tx1_valid_reg && tx1_hdr_reg[71] &&
        tx1_hdr_reg[69:68] != 2'h0 && tx1_hdr_reg[67:64] < 4'h4 && !write_req_nearly_full
        |=> tx1_valid_reg && !tx1_hdr_reg[71] &&
        tx1_hdr_reg[17:16] == $past(tx1_hdr_reg[17:16]) + 2'h1)
        else $error("second beat missing or address wrong");
    a_fence_reserved: assert property (tx1_valid_reg && tx1_hdr_reg[67:64] == 4'h4 |->
        tx1_hdr_reg[79:74] == 6'h00 && tx1_hdr_reg[71:68] == 4'h0 && tx1_hdr_reg[63:16] == 48'h0)
        else $error("fence reserved bits set");
    a_intr_reserved: assert property (tx1_valid_reg && tx1_hdr_reg[67:64] == 4'h6 |->
        tx1_hdr_reg[79:74] == 6'h00 && tx1_hdr_reg[71:68] == 4'h0 && tx1_hdr_reg[63:2] == 62'h0)
        else $error("interrupt reserved bits set");
    a_reply_echo: assert property (reg_read_strobe |=>
        tx2_valid && tx2_hdr == $past(rx0_hdr[8:0]))
        else $error("read reply late or tag wrong");
    a_reply_cause: assert property (tx2_valid |-> $past(reg_read_strobe))
        else $error("read reply without request");
endmodule // alhr_props
bind alhr_top alhr_props i_props (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pready_reg(pready_reg), .pslverr_reg(pslverr_reg),
    .write_req_nearly_full(write_req_nearly_full), .tx1_valid_reg(tx1_valid_reg),
    .tx1_hdr_reg(tx1_hdr_reg), .tx2_valid(tx2_valid), .tx2_hdr(tx2_hdr),
    .rx0_hdr(rx0_hdr), .reg_read_strobe(reg_read_strobe));
`default_nettype wire

// File: test/alhr_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module alhr_host_model (
    // Clock
    input  wire logic         pclk,
    // Transmit channel 1
    input  wire logic         tx1_valid_reg,
    input  wire logic [79:0]  tx1_hdr_reg,
    input  wire logic [511:0] tx1_data_reg,
    // Backpressure
    output var  logic         read_req_nearly_full,
    output var  logic         write_req_nearly_full,
    // Receive channels
    output var  logic [27:0]  rx0_hdr,
    output var  logic [511:0] rx0_data,
    output var  logic         rx0_response_strobe,
    output var  logic         reg_read_strobe,
    output var  logic         reg_write_strobe,
    output var  logic [27:0]  rx1_hdr,
    output var  logic         rx1_response_strobe
);
    logic [79:0]  hq[$];
    logic [511:0] dq[$];
    initial begin
        {read_req_nearly_full, write_req_nearly_full} = 2'h0;
        {rx0_response_strobe, reg_read_strobe, reg_write_strobe} = 3'h0;
        rx1_response_strobe = 1'b0;
        rx0_hdr = 28'h0;
        rx0_data = 512'h0;
        rx1_hdr = 28'h0;
    end
    always @(posedge pclk) begin
        if (tx1_valid_reg) begin
            hq.push_back(tx1_hdr_reg);
            dq.push_back(tx1_data_reg);
        end
    end
    // Kind 0 memory response, 1 register read, 2 register write; one strobe per call.
    task automatic send0(input logic [1:0] kind, input logic [27:0] hdr, input logic [511:0] d);
        @(posedge pclk);
        rx0_hdr <= hdr;
        rx0_data <= d;
        rx0_response_strobe <= (kind == 2'h0);
        reg_read_strobe <= (kind == 2'h1);
        reg_write_strobe <= (kind == 2'h2);
        @(posedge pclk);
        {rx0_response_strobe, reg_read_strobe, reg_write_strobe} <= 3'h0;
        rx0_hdr <= ~hdr;
        rx0_data <= ~d;
    endtask
    task automatic send1(input logic [27:0] hdr);
        @(posedge pclk);
        rx1_hdr <= hdr;
        rx1_response_strobe <= 1'b1;
        @(posedge pclk);
        rx1_response_strobe <= 1'b0;
        rx1_hdr <= ~hdr;
    endtask
    task automatic stall(input int n);
        @(posedge pclk);
        {read_req_nearly_full, write_req_nearly_full} <= 2'h3;
        repeat (n) @(posedge pclk);
        {read_req_nearly_full, write_req_nearly_full} <= 2'h0;
    endtask
endmodule // alhr_host_model
`default_nettype wire

// File: test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "alhr_consts.vh"
module tb_top;
    logic pclk, presetn, psel, penable, pwrite, pready_reg, pslverr_reg, err_seen;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata_reg, rd;
    logic rnf, wnf, tx1_valid_reg, tx2_valid, rx0_rs, rrs, rws, rx1_rs;
    logic [79:0] tx1_hdr_reg;
    logic [511:0] tx1_data_reg, rx0_data;
    logic [8:0] tx2_hdr;
    logic [63:0] tx2_data;
    logic [27:0] rx0_hdr, rx1_hdr;
    logic [41:0] a;
    int errors, num_checks, t, k;
    alhr_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_reg(prdata_reg),
        .pready_reg(pready_reg), .pslverr_reg(pslverr_reg), .read_req_nearly_full(rnf),
        .write_req_nearly_full(wnf), .tx1_valid_reg(tx1_valid_reg), .tx1_hdr_reg(tx1_hdr_reg),
        .tx1_data_reg(tx1_data_reg), .tx2_valid(tx2_valid), .tx2_hdr(tx2_hdr),
        .tx2_data(tx2_data), .rx0_hdr(rx0_hdr), .rx0_data(rx0_data),
        .rx0_response_strobe(rx0_rs), .reg_read_strobe(rrs), .reg_write_strobe(rws),
        .rx1_hdr(rx1_hdr), .rx1_response_strobe(rx1_rs));
    alhr_host_model i_host (.pclk(pclk), .tx1_valid_reg(tx1_valid_reg),
        .tx1_hdr_reg(tx1_hdr_reg), .tx1_data_reg(tx1_data_reg), .read_req_nearly_full(rnf),
        .write_req_nearly_full(wnf), .rx0_hdr(rx0_hdr), .rx0_data(rx0_data),
        .rx0_response_strobe(rx0_rs), .reg_read_strobe(rrs), .reg_write_strobe(rws),
        .rx1_hdr(rx1_hdr), .rx1_response_strobe(rx1_rs));
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    task automatic give_verdict();
        if (errors == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic check(input string nm, input logic [511:0] seen, input logic [511:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s: expected %0h seen %0h", nm, exp, seen);
        end
    endtask
    // Every call starts one edge on, so psel is never assigned twice in a time step.
    task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
        int n;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, ad, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready_reg !== 1'b1 && n < 50);
        if (n >= 50) begin
            errors++;
            give_verdict();
        end
        rd = prdata_reg;
        err_seen = pslverr_reg;
        {psel, penable} <= 2'h0;
    endtask
    task automatic rchk(input logic [7:0] ad, input logic [31:0] exp);
        apb(1'b0, ad, 32'h0);
        check("read word", rd, exp);
    endtask
    task automatic beats(input int n);
        int i;
        for (i = 0; i < 300 && i_host.hq.size() < n; i++) @(posedge pclk);
        if (i_host.hq.size() < n) begin
            errors++;
            give_verdict();
        end
    endtask
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = 44'h0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rchk(`ALHR_OFS_STATUS, 32'h0);
        rchk(`ALHR_OFS_WR_CNT, 32'h0);
        rchk(8'hFC, 32'h0);
        check("unmapped error", err_seen, 1'b1);
        for (t = 0; t < 3; t++) begin
            a = {10'h155, 32'h89ABCDE0 | t};
            apb(1'b1, `ALHR_OFS_ADDR_LO, a[31:0]);
            apb(1'b1, `ALHR_OFS_ADDR_HI, 32'h155);
            apb(1'b1, `ALHR_OFS_TAG, 32'h5A00 + t);
            apb(1'b1, `ALHR_OFS_WDATA, 32'hC0DE0000 + t);
            i_host.hq.delete();
            i_host.dq.delete();
            apb(1'b1, `ALHR_OFS_CMD, (t << 6) | (t << 4) | t);
            beats(t + 1);
            check("first beat", i_host.hq[0], {6'h0, 2'(t), 2'h2, 2'(t), 4'(t), 6'h0, a, 8'h5A, 8'(t)});
            check("beat data", i_host.dq[0], {16{32'hC0DE0000 + t}});
            for (k = 1; k <= t; k++) check("later beat", {i_host.hq[k][71:70], i_host.hq[k][67:64], i_host.hq[k][17:16]}, {2'h0, 4'(t), 2'(t + k)});
            rchk(`ALHR_OFS_STATUS, (t + 1) << 8);
            i_host.send1({4'h1, 1'b1, 1'b0, 2'(t), 20'h0});
            rchk(`ALHR_OFS_STATUS, 32'h0);
        end
        i_host.hq.delete();
        apb(1'b1, `ALHR_OFS_BYTES, 32'h0705);
        apb(1'b1, `ALHR_OFS_CMD, 32'h140);
        beats(2);
        check("partial beat", {i_host.hq[0][79:74], i_host.hq[0][70], i_host.hq[0][63:58]}, {6'h07, 1'b1, 6'h05});
        check("partial tail", {i_host.hq[1][79:74], i_host.hq[1][70], i_host.hq[1][63:58]}, 13'h0);
        i_host.send1({4'h1, 1'b0, 3'h0, 20'h0});
        i_host.send1({4'h1, 1'b0, 3'h1, 20'h0});
        rchk(`ALHR_OFS_STATUS, 32'h0);
        rchk(`ALHR_OFS_WR_CNT, 32'h5);
        i_host.hq.delete();
        apb(1'b1, `ALHR_OFS_TAG, 32'hBEEF);
        fork
            i_host.stall(30);
            begin
                apb(1'b1, `ALHR_OFS_CMD, 32'h24);
                apb(1'b1, `ALHR_OFS_CMD, 32'h436);
                check("no beat when full", i_host.hq.size(), 0);
                rchk(`ALHR_OFS_STATUS, 32'hF);
            end
        join
        beats(1);
        check("fence", i_host.hq[0], {6'h0, 2'h2, 4'h0, 4'h4, 48'h0, 16'hBEEF});
        apb(1'b1, `ALHR_OFS_STATUS, 32'h2);
        apb(1'b1, `ALHR_OFS_CMD, 32'h3);
        rchk(`ALHR_OFS_STATUS, 32'h2);
        apb(1'b1, `ALHR_OFS_STATUS, 32'h2);
        apb(1'b1, `ALHR_OFS_CMD, 32'h436);
        beats(2);
        check("interrupt", i_host.hq[1], {6'h0, 2'h3, 4'h0, 4'h6, 62'h0, 2'h2});
        i_host.send0(2'h2, {16'h0, 2'h1, 10'h0}, 64'h0123456789ABCDEF);
        rchk(`ALHR_OFS_MAILBOX, 32'h89ABCDEF);
        i_host.send0(2'h1, {16'h0, 2'h1, 1'b0, 9'h1A5}, 512'h0);
        #1;
        check("reply 8 byte", {tx2_valid, tx2_hdr, tx2_data}, {1'b1, 9'h1A5, 64'h0123456789ABCDEF});
        i_host.send0(2'h1, {16'h1, 2'h0, 1'b0, 9'h0C3}, 512'h0);
        #1;
        check("reply 4 byte", {tx2_valid, tx2_hdr, tx2_data}, {1'b1, 9'h0C3, 64'h01234567});
        i_host.send0(2'h0, 28'h0, {480'h0, 32'h600DF00D});
        i_host.send0(2'h0, {4'h4, 24'h0}, {480'h0, 32'h7E57DA7A});
        rchk(`ALHR_OFS_RD_CNT, 32'h1);
        rchk(`ALHR_OFS_MSG_CNT, 32'h1);
        rchk(`ALHR_OFS_LAST_DATA, 32'h7E57DA7A);
        give_verdict();
    end
endmodule // tb_top
`default_nettype wire
